// ===== sdpp_regs.vh
// Constants for the synthesizer divider programming port.
`ifndef SDPP_REGS_VH
`define SDPP_REGS_VH
`define SDPP_AW 4
`define SDPP_A_CTRL 4'h0
`define SDPP_A_PAR 4'h4
`define SDPP_A_STAT 4'h8
`define SDPP_A_DIV 4'hC
`define SDPP_M_W 9
`define SDPP_N_W 3
`define SDPP_SHIFT_W 12
`define SDPP_M_RESET 9'h020
`define SDPP_N_RESET 3'h3
`define SDPP_N_DIV2 3'h1
`define SDPP_N_DIV4 3'h3
`define SDPP_N_DIV5 3'h4
`define SDPP_CTRL_RESET 32'h0000_0001
`define SDPP_RESP_OKAY 2'b00
`define SDPP_RESP_SLVERR 2'b10
`endif

// ===== sdpp_sync.v
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module sdpp_sync #(
    parameter WIDTH = 1,
    parameter RESET_VAL = 0
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= RESET_VAL[WIDTH-1:0];
            sync_q <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // sdpp_sync

// ===== sdpp_top.v
// Divider programming port with parallel and serial loading and an AXI4-Lite view.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sdpp_regs.vh"

// Operation
// - Master reset holds PLL, keeps divider values.
// - Parallel load low passes pins straight through; with CTRL bit 1 set the PAR values pass instead.
// - Parallel mode drives shift monitor low.
// - Parallel load rise captures pins, holds them; with CTRL bit 1 set it captures the PAR values.
// - Every feedback pin captured on load rise; with CTRL bit 1 set the PAR feedback value instead.
// - Strobe loads nine feedback, three output bits.
// - Shift clock rise shifts serial bit in.
// - Transfer rise moves shift register to dividers.
// - Transfer fall latches current divider values.
// - No shift-clock edge, shift register unchanged.
// - Transfer high passes serial bit to feedback.
// - Feedback value is unsigned binary, weights 256..1.
// - One output code sets both banks' divide.
// - Bypass select chooses PLL or bypass path.
module sdpp_top (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_master_reset,
    input wire i_parallel_load_n,
    input wire [`SDPP_M_W-1:0] i_feedback_divide_bits,
    input wire [`SDPP_N_W-1:0] i_output_divide_bits,
    input wire i_serial_shift_clock,
    input wire i_serial_bit_in,
    input wire i_serial_transfer,
    input wire i_pll_bypass_select,
    input wire [`SDPP_AW-1:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [`SDPP_AW-1:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    output reg [`SDPP_M_W-1:0] o_feedback_divide,
    output reg [`SDPP_N_W-1:0] o_output_divide,
    output reg [2:0] o_output_ratio,
    output reg o_pll_reset,
    output reg o_pll_bypass,
    output reg o_shift_monitor_out
);
    localparam SW = `SDPP_SHIFT_W;
    localparam PIN_W = 5 + `SDPP_M_W + `SDPP_N_W;
    // Pull defaults: load strobe low, bypass select high, feedback 32, output 4.
    localparam [PIN_W-1:0] PIN_RST = {1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
        `SDPP_M_RESET, `SDPP_N_RESET};

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.
    wire [PIN_W-1:0] pins_s;
    wire mr_s, pl_n_s, sck_s, sdi_s, sld_s, byp_s;
    wire [`SDPP_M_W-1:0] m_pin_s;
    wire [`SDPP_N_W-1:0] n_pin_s;

    sdpp_sync #(.WIDTH(PIN_W), .RESET_VAL(PIN_RST)) u_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async({i_parallel_load_n, i_serial_shift_clock, i_serial_bit_in,
            i_serial_transfer, i_pll_bypass_select, i_feedback_divide_bits,
            i_output_divide_bits}),
        .o_sync(pins_s)
    );

    assign {pl_n_s, sck_s, sdi_s, sld_s, byp_s, m_pin_s, n_pin_s} = pins_s;

    // Master reset is kept out of the bundle so its reset value is low.
    reg mr_meta_q, mr_sync_q;
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mr_meta_q <= 1'b0;
            mr_sync_q <= 1'b0;
        end else begin
            mr_meta_q <= i_master_reset;
            mr_sync_q <= mr_meta_q;
        end
    end
    assign mr_s = mr_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised pins.
    reg pl_n_q, sck_q, sld_q;
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pl_n_q <= 1'b0;
            sck_q <= 1'b0;
            sld_q <= 1'b0;
        end else begin
            pl_n_q <= pl_n_s;
            sck_q <= sck_s;
            sld_q <= sld_s;
        end
    end
    wire pl_rise = pl_n_s & ~pl_n_q;
    wire sck_rise = sck_s & ~sck_q;
    wire sld_rise = sld_s & ~sld_q;
    wire sld_fall = ~sld_s & sld_q;

    ////////////////////////////////////////////////////////////////////////////
    // Control register and software parallel override.
    reg [31:0] ctrl_q;
    reg [`SDPP_M_W-1:0] sw_m_q;
    reg [`SDPP_N_W-1:0] sw_n_q;
    wire sw_en = ctrl_q[1];

    // Output code to divide ratio; unlisted codes report zero.
    function [2:0] ratio_of;
        input [`SDPP_N_W-1:0] code;
        begin
            case (code)
                `SDPP_N_DIV2: ratio_of = 3'h2;
                `SDPP_N_DIV4: ratio_of = 3'h4;
                `SDPP_N_DIV5: ratio_of = 3'h5;
                default: ratio_of = 3'h0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Programming engine.
    reg [SW-1:0] shift_q;
    reg [`SDPP_M_W-1:0] m_q;
    reg [`SDPP_N_W-1:0] n_q;
    reg [`SDPP_M_W-1:0] m_hold_q;
    reg [`SDPP_N_W-1:0] n_hold_q;
    reg [`SDPP_M_W-1:0] m_src;
    reg [`SDPP_N_W-1:0] n_src;
    reg [`SDPP_M_W-1:0] m_d;
    reg [`SDPP_N_W-1:0] n_d;

    always @* begin
        m_src = sw_en ? sw_m_q : m_pin_s;
        n_src = sw_en ? sw_n_q : n_pin_s;
        m_d = m_q;
        n_d = n_q;
        if (!pl_n_s) begin
            m_d = m_src;
            n_d = n_src;
        end else if (pl_rise && !sld_s) begin
            m_d = m_src;
            n_d = n_src;
        end else if (sld_rise && !sck_s) begin
            m_d = shift_q[SW-1:`SDPP_N_W];
            n_d = shift_q[`SDPP_N_W-1:0];
        end else if (sld_s && sld_q && sck_rise) begin
            m_d = {m_q[`SDPP_M_W-2:0], sdi_s};
        end
    end

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_q <= {SW{1'b0}};
            m_q <= `SDPP_M_RESET;
            n_q <= `SDPP_N_RESET;
            m_hold_q <= `SDPP_M_RESET;
            n_hold_q <= `SDPP_N_RESET;
        end else begin
            // Master reset is not a term here, so loaded values survive it.
            m_q <= m_d;
            n_q <= n_d;
            if (pl_n_s && !sld_s && sck_rise) begin
                shift_q <= {shift_q[SW-2:0], sdi_s};
            end
            if (sld_fall && !sck_s) begin
                m_hold_q <= m_q;
                n_hold_q <= n_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_feedback_divide <= `SDPP_M_RESET;
            o_output_divide <= `SDPP_N_RESET;
            o_output_ratio <= 3'h4;
            o_pll_reset <= 1'b0;
            o_pll_bypass <= 1'b0;
            o_shift_monitor_out <= 1'b0;
        end else begin
            o_feedback_divide <= m_d;
            o_output_divide <= n_d;
            o_output_ratio <= ratio_of(n_d);
            o_pll_reset <= mr_s | ctrl_q[2];
            // Bypass select high means PLL mode.
            o_pll_bypass <= ~byp_s;
            o_shift_monitor_out <= pl_n_s ? shift_q[SW-1] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.
    reg aw_got_q, w_got_q;
    reg [`SDPP_AW-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_hs = i_awvalid & o_awready;
    wire w_hs = i_wvalid & o_wready;
    wire do_wr = aw_got_q & w_got_q & ~o_bvalid;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (st[k]) begin
                    merge[8*k +: 8] = nw[8*k +: 8];
                end
            end
        end
    endfunction

    wire [31:0] par_word = {19'h0_0000, sw_n_q, 1'b0, sw_m_q};
    wire [31:0] par_new = merge(par_word, wdata_q, wstrb_q);

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= {`SDPP_AW{1'b0}};
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `SDPP_RESP_OKAY;
            ctrl_q <= `SDPP_CTRL_RESET;
            sw_m_q <= `SDPP_M_RESET;
            sw_n_q <= `SDPP_N_RESET;
        end else begin
            if (aw_hs) begin
                awaddr_q <= i_awaddr;
                aw_got_q <= 1'b1;
                o_awready <= 1'b0;
            end
            if (w_hs) begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
                w_got_q <= 1'b1;
                o_wready <= 1'b0;
            end
            if (do_wr) begin
                o_bvalid <= 1'b1;
                o_bresp <= `SDPP_RESP_OKAY;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                case (awaddr_q)
                    `SDPP_A_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) &
                        32'h0000_0006;
                    `SDPP_A_PAR: begin
                        sw_m_q <= par_new[`SDPP_M_W-1:0];
                        sw_n_q <= par_new[12:10];
                    end
                    default: o_bresp <= `SDPP_RESP_SLVERR;
                endcase
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `SDPP_RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rresp <= `SDPP_RESP_OKAY;
                case (i_araddr)
                    `SDPP_A_CTRL: o_rdata <= ctrl_q;
                    `SDPP_A_PAR: o_rdata <= par_word;
                    `SDPP_A_STAT: o_rdata <= {24'h00_0000, o_pll_reset, o_pll_bypass,
                        o_shift_monitor_out, mr_s, pl_n_s, sld_s, sck_s, sdi_s};
                    `SDPP_A_DIV: o_rdata <= {3'h0, n_hold_q, 1'b0, m_hold_q,
                        1'b0, n_q, 3'h0, m_q};
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= `SDPP_RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end
endmodule // sdpp_top

// ===== sdpp_assertions.sv
// Concurrent checks on the ports of the divider programming port.
`timescale 1ns/1ps
`include "sdpp_regs.vh"
module sdpp_checker (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_master_reset,
    input wire i_parallel_load_n,
    input wire [`SDPP_M_W-1:0] i_feedback_divide_bits,
    input wire i_serial_transfer,
    input wire i_pll_bypass_select,
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire o_bvalid,
    input wire i_arvalid,
    input wire o_arready,
    input wire o_rvalid,
    input wire [`SDPP_M_W-1:0] o_feedback_divide,
    input wire [`SDPP_N_W-1:0] o_output_divide,
    input wire [2:0] o_output_ratio,
    input wire o_pll_reset,
    input wire o_pll_bypass,
    input wire o_shift_monitor_out
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    function automatic [2:0] ratio_of(input [2:0] c);
        case (c)
            `SDPP_N_DIV2: ratio_of = 3'h2;
            `SDPP_N_DIV4: ratio_of = 3'h4;
            `SDPP_N_DIV5: ratio_of = 3'h5;
            default: ratio_of = 3'h0;
        endcase
    endfunction
    a_monitor_low: assert property ((!i_parallel_load_n) [*5] |-> !o_shift_monitor_out)
        else $error("monitor high in parallel mode");
    a_pass_through: assert property ((!i_parallel_load_n && !i_serial_transfer
        && $stable(i_feedback_divide_bits)) [*5] |-> o_feedback_divide == i_feedback_divide_bits)
        else $error("feedback not passed through");
    a_ratio_map: assert property ($stable(o_output_divide) |->
        o_output_ratio == ratio_of(o_output_divide))
        else $error("ratio does not match code");
    a_bypass_follows: assert property ($stable(i_pll_bypass_select) [*5] |->
        o_pll_bypass == !i_pll_bypass_select)
        else $error("bypass does not follow select");
    a_pll_held: assert property (i_master_reset [*5] |-> o_pll_reset)
        else $error("pll not held in reset");
    a_hold_loaded: assert property ((i_parallel_load_n && !i_serial_transfer) [*6] |->
        $stable(o_feedback_divide))
        else $error("loaded feedback changed");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##[1:3] o_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
        else $error("read response missing");
endmodule // sdpp_checker
bind sdpp_top sdpp_checker i_chk (.*);

// ===== sdpp_ctrl_model.sv
// External controller model driving the serial programming pins.
`timescale 1ns/1ps
module sdpp_ctrl_model (
    output logic o_clk,
    output logic o_dat,
    output logic o_xfer
);
    initial begin
        o_clk = 1'b0;
        o_dat = 1'b0;
        o_xfer = 1'b0;
    end
    // Sends n bits, top bit first; the clock stands still outside the frame.
    task automatic shift(input int n, input logic [11:0] w);
        for (int i = n - 1; i >= 0; i--) begin
            o_dat <= w[i];
            #100 o_clk <= 1'b1;
            #100 o_clk <= 1'b0;
        end
        #100 o_dat <= ~w[0];
    endtask
    task automatic xfer(input logic v);
        #100 o_xfer <= v;
        #300;
    endtask
endmodule // sdpp_ctrl_model

// ===== sdpp_top_test.sv
// Self-checking bench for the divider programming port.
`timescale 1ns/1ps
`include "sdpp_regs.vh"
module sdpp_top_test;
    logic i_clock = 1'b0, i_reset_n = 1'b0, i_master_reset = 1'b0, i_parallel_load_n = 1'b0;
    logic [8:0] i_feedback_divide_bits = `SDPP_M_RESET;
    logic [2:0] i_output_divide_bits = `SDPP_N_RESET;
    logic i_pll_bypass_select = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0;
    logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
    logic [31:0] i_wdata = 32'h0000_0000, d, seed = 32'h0000_c005;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pll_reset, o_pll_bypass;
    wire o_shift_monitor_out, i_serial_shift_clock, i_serial_bit_in, i_serial_transfer;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire [8:0] o_feedback_divide;
    wire [2:0] o_output_divide, o_output_ratio;
    logic [2:0] codes [3] = '{`SDPP_N_DIV2, `SDPP_N_DIV4, `SDPP_N_DIV5};
    logic [8:0] m;
    logic [2:0] c, b;
    logic [11:0] w;
    int fail_count = 0, checks = 0;
    sdpp_top i_dut (.*);
    sdpp_ctrl_model i_ctrl (.o_clk(i_serial_shift_clock), .o_dat(i_serial_bit_in),
        .o_xfer(i_serial_transfer));
    always #12.5 i_clock = ~i_clock;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] exp_ratio(input logic [2:0] k);
        return (k == `SDPP_N_DIV2) ? 3'h2 : (k == `SDPP_N_DIV4) ? 3'h4 : 3'h5;
    endfunction
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 40) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge i_clock);
    endtask
    // Each call first lets an edge pass, so a release and the next raise never share a step.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
        int n;
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) break;
        end
        if (n < 40) check("bresp", r, o_bresp);
        i_bready <= 1'b0;
        guard(n);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [1:0] r);
        int n;
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge i_clock);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) break;
        end
        d = o_rdata;
        if (n < 40) check("rresp", r, o_rresp);
        i_rready <= 1'b0;
        guard(n);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_clock);
        i_reset_n <= 1'b1;
        settle();
        check("feedback", `SDPP_M_RESET, o_feedback_divide);
        check("ratio", 3'h4, o_output_ratio);
        axi_rd(`SDPP_A_CTRL, `SDPP_RESP_OKAY);
        check("ctrl", `SDPP_CTRL_RESET, d);
        axi_rd(4'h2, `SDPP_RESP_SLVERR);
        check("unmapped rdata", 32'h0000_0000, d);
        axi_wr(`SDPP_A_STAT, 32'hffff_ffff, `SDPP_RESP_SLVERR);
        for (int k = 0; k < 8; k++) begin
            d = rnd();
            m = (k == 0) ? 9'h1ff : (k == 1) ? 9'h000 : d[8:0];
            c = codes[k % 3];
            i_parallel_load_n <= 1'b0;
            i_feedback_divide_bits <= m;
            i_output_divide_bits <= c;
            settle();
            check("pass feedback", m, o_feedback_divide);
            check("monitor", 1'b0, o_shift_monitor_out);
            check("ratio", exp_ratio(c), o_output_ratio);
            i_parallel_load_n <= 1'b1;
            settle();
            i_feedback_divide_bits <= ~m;
            i_output_divide_bits <= ~c;
            settle();
            check("held feedback", m, o_feedback_divide);
            check("held code", c, o_output_divide);
        end
        $display("test parallel done");
        i_master_reset <= 1'b1;
        settle();
        check("pll reset", 1'b1, o_pll_reset);
        check("feedback", m, o_feedback_divide);
        i_master_reset <= 1'b0;
        i_pll_bypass_select <= 1'b0;
        settle();
        check("bypass", 1'b1, o_pll_bypass);
        i_pll_bypass_select <= 1'b1;
        settle();
        check("bypass", 1'b0, o_pll_bypass);
        d = rnd();
        w = d[11:0];
        b = d[14:12];
        i_ctrl.shift(12, w);
        i_ctrl.xfer(1'b1);
        i_ctrl.xfer(1'b0);
        settle();
        check("serial feedback", w[11:3], o_feedback_divide);
        check("serial code", w[2:0], o_output_divide);
        check("serial monitor", w[11], o_shift_monitor_out);
        i_feedback_divide_bits <= d[24:16];
        settle();
        i_ctrl.xfer(1'b1);
        i_ctrl.shift(3, {9'h000, b});
        settle();
        check("direct feedback", {w[8:3], b}, o_feedback_divide);
        i_ctrl.xfer(1'b0);
        settle();
        check("latched feedback", {w[8:3], b}, o_feedback_divide);
        $display("test serial done");
        axi_wr(`SDPP_A_PAR, {19'h0_0000, c, 1'b0, m}, `SDPP_RESP_OKAY);
        axi_rd(`SDPP_A_PAR, `SDPP_RESP_OKAY);
        check("par", {19'h0_0000, c, 1'b0, m}, d);
        axi_rd(`SDPP_A_DIV, `SDPP_RESP_OKAY);
        check("div feedback", {w[8:3], b}, d[8:0]);
        check("div latched", {w[8:3], b}, d[24:16]);
        // Software override: a short load pulse must capture the PAR values, not the pins.
        axi_wr(`SDPP_A_CTRL, 32'h0000_0002, `SDPP_RESP_OKAY);
        i_parallel_load_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_parallel_load_n <= 1'b1;
        settle();
        check("override feedback", m, o_feedback_divide);
        check("override code", c, o_output_divide);
        axi_wr(`SDPP_A_CTRL, 32'h0000_0004, `SDPP_RESP_OKAY);
        settle();
        check("pll reset", 1'b1, o_pll_reset);
        axi_wr(`SDPP_A_CTRL, 32'h0000_0000, `SDPP_RESP_OKAY);
        settle();
        check("pll reset", 1'b0, o_pll_reset);
        $display("test registers done");
        conclude();
    end
endmodule // sdpp_top_test
